/* inband_pkg.sv */
// Shared constants, types and field layouts for the in-band management block.
// Assumes byte-wide frame streams without preamble or FCS, and a 32-bit register space.
package inband_pkg;

  // ****************************************************************
  // Frame layout, byte offsets from the first destination byte
  // ****************************************************************
  localparam int DA_OFS = 0;
  localparam int SA_OFS = 6;
  localparam int ADDR_BYTES = 6;
  localparam int TAG_TYPE_OFS = 12;
  localparam int TAG_CTRL_OFS = 14;
  localparam int CFI_BIT = 4;
  localparam int ETYPE_OFS = 16;
  localparam int HDR_BYTES = 18;
  localparam int CODE_OFS = 20;
  localparam int LIST_OFS = 22;
  localparam int WORD_BYTES = 4;
  localparam int CMD_BYTES = 8;

  // Tag type and length/type identifying a management frame; values are arbitrary
  localparam logic [15:0] TAG_TYPE_DEF = 16'h5a00;
  localparam logic [15:0] ETYPE_DEF = 16'h0000;

  // ****************************************************************
  // Access codes and command fields
  // ****************************************************************
  localparam logic [15:0] MODE_SINGLE = 16'h0001;
  localparam logic [15:0] MODE_BURST = 16'h0002;
  localparam int OP_MSB = 31;
  localparam int BE_MSB = 27;
  localparam int DIR_MSB = 31;
  localparam int CNT_W = 6;
  localparam logic [2:0] OP_END = 3'h0;
  localparam logic [2:0] OP_READ = 3'h1;
  localparam logic [2:0] OP_WRITE = 3'h2;
  localparam logic [2:0] OP_WAIT0 = 3'h4;
  localparam logic [2:0] OP_WAIT1 = 3'h5;
  localparam logic [2:0] OP_CLR = 3'h6;
  localparam logic [2:0] OP_SET = 3'h7;
  localparam logic [1:0] DIR_READ = 2'h1;
  localparam logic [1:0] DIR_WRITE = 2'h2;
  localparam logic [3:0] BE_ALL = 4'hf;

  // ****************************************************************
  // Control registers on the Avalon slave
  // ****************************************************************
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam int EN_BIT = 0;
  localparam int PORT_LSB = 4;
  localparam int PORT_W = 3;
  localparam logic [2:0] DEF_PORT = 3'h7;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_FETCH = 4'b0010,
    S_BUS = 4'b0100,
    S_TX = 4'b1000
  } state_t;

  typedef struct packed {
    logic sof;
    logic eof;
    logic [2:0] port;
    logic [7:0] data;
  } rx_beat_t;

  typedef struct packed {
    logic last;
    logic [7:0] data;
  } tx_beat_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] be;
    logic [23:0] addr;
    logic [31:0] wdata;
  } sw_req_t;

endpackage

/* inband_ctrl_regs.sv */
// Avalon-MM slave holding the in-band control register and the status view.
// Assumes a master that holds each request until it samples waitrequest low.
`timescale 1ns/1ns
module inband_ctrl_regs (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic strap_en_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] status_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic mgmt_en_o,
  output logic [2:0] mgmt_port_o
);

  logic strap_done;
  logic take;

  assign take = (avs_read_i || avs_write_i) && !avs_waitrequest_o;

  // ****************************************************************
  // Bus handshake: answer one cycle after a request is seen
  // ****************************************************************
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b0;
      case (avs_address_i)
        inband_pkg::CTRL_OFS: begin
          avs_readdata_o <= 32'h0000_0000;
          avs_readdata_o[inband_pkg::EN_BIT] <= mgmt_en_o;
          avs_readdata_o[inband_pkg::PORT_LSB +: inband_pkg::PORT_W] <= mgmt_port_o;
        end
        inband_pkg::STAT_OFS: avs_readdata_o <= status_i;
        default: avs_readdata_o <= 32'h0000_0000; // Unmapped reads as zero
      endcase
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  // ****************************************************************
  // Control register; enable is loaded from the strap after reset
  // ****************************************************************
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      strap_done <= 1'b0;
      mgmt_en_o <= 1'b0;
      mgmt_port_o <= inband_pkg::DEF_PORT;
    end else if (!strap_done) begin
      // Strap caught on the first edge after release, never inside reset
      strap_done <= 1'b1;
      mgmt_en_o <= strap_en_i;
    end else if (take && avs_write_i && avs_address_i == inband_pkg::CTRL_OFS &&
                 avs_byteenable_i[0]) begin
      mgmt_en_o <= avs_writedata_i[inband_pkg::EN_BIT];
      mgmt_port_o <= avs_writedata_i[inband_pkg::PORT_LSB +: inband_pkg::PORT_W];
    end
  end

endmodule

/* inband_register_access.sv */
// In-band management command interpreter: captures management frames on one port,
// runs their command list on the switch register bus and sends back a response.
// Assumes rx bytes without FCS, a fabric that obeys the discard pulse at end of
// frame, and a register bus that acknowledges with a one-cycle pulse.
`timescale 1ns/1ns
// Notes on behaviour
// - After reset port 7 is the management port until software picks another.
// - Management is enabled or disabled by a strap caught after reset.
// - Only the one selected and enabled port is examined for management frames.
// - The selected port still carries ordinary traffic untouched.
// - Management frames are flagged so lookups, tagging and filters skip them.
// - Management frames are discarded by the fabric, never forwarded.
// - Response frame swaps destination and source addresses.
// - Four byte tag follows the source, then the two byte length/type.
// - Tag control holds priority, zero canonical bit, mode and sequence.
// - One frame at a time; others dropped until response fully sent.
// - Burst accesses are full 32-bit words; single commands use the command word's byte enables.
// - Access code 0x0001 selects command list, 0x0002 selects burst.
// - Op codes: read, write, wait zero, wait one, clear and set masked bits.
// - Op code zero ends the command list.
// - Command word carries four byte enables and a 24-bit address.
// - Wait and modify commands take a following mask word.
// - Burst word carries direction and 24-bit start address.
// - Burst count is six bits, bounded by the frame buffer.
module inband_register_access #(
  parameter int BUF_BYTES = 256,
  parameter logic [15:0] TAG_TYPE = inband_pkg::TAG_TYPE_DEF,
  parameter logic [15:0] ETYPE = inband_pkg::ETYPE_DEF
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic strap_en_i,
  input wire logic [47:0] switch_mac_i,
  input wire logic rx_valid_i,
  input wire inband_pkg::rx_beat_t rx_i,
  output logic mgmt_frame_o,
  output logic fabric_discard_o,
  output inband_pkg::sw_req_t sw_req_o,
  input wire logic [31:0] sw_rdata_i,
  input wire logic sw_ack_i,
  output logic tx_valid_o,
  output inband_pkg::tx_beat_t tx_o,
  input wire logic tx_ready_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o
);

  localparam int AW = $clog2(BUF_BYTES);
  localparam int PW = AW + 1;

  inband_pkg::state_t state;
  logic [7:0] mem [BUF_BYTES];
  logic mgmt_en;
  logic [2:0] mgmt_port;
  logic [PW-1:0] rx_cnt;
  logic [PW-1:0] byte_idx;
  logic [PW-1:0] len;
  logic [PW-1:0] ptr;
  logic [PW-1:0] tx_idx;
  logic hdr_ok;
  logic hdr_run;
  logic cap;
  logic cap_now;
  logic sel;
  logic is_mgmt;
  logic start;
  logic rx_we;
  logic ex_we;
  logic [AW-1:0] ex_widx;
  logic burst_on;
  logic [1:0] bdir;
  logic [23:0] baddr;
  logic [inband_pkg::CNT_W-1:0] bleft;
  logic [2:0] op_r;
  logic [31:0] mask_r;
  logic mod_wr;
  logic [31:0] cw;
  logic [31:0] dw;
  logic [15:0] mode;
  logic tx_done;
  logic [7:0] done_cnt;
  logic [7:0] drop_cnt;
  logic [31:0] status;

  // ****************
  // Helpers
  // ****************
  function automatic logic [31:0] word_at(input logic [AW-1:0] p);
    return {mem[p], mem[p + AW'(1)], mem[p + AW'(2)], mem[p + AW'(3)]};
  endfunction

  // Checks one header byte against the management frame signature
  function automatic logic hdr_byte_ok(input logic [PW-1:0] i, input logic [7:0] d);
    int k;
    logic ok;
    k = int'(i);
    ok = 1'b1;
    if (k < inband_pkg::ADDR_BYTES) begin
      ok = (d == switch_mac_i[8 * (5 - k) +: 8]);
    end else if (k == inband_pkg::TAG_TYPE_OFS) begin
      ok = (d == TAG_TYPE[15:8]);
    end else if (k == inband_pkg::TAG_TYPE_OFS + 1) begin
      ok = (d == TAG_TYPE[7:0]);
    end else if (k == inband_pkg::TAG_CTRL_OFS) begin
      ok = !d[inband_pkg::CFI_BIT];
    end else if (k == inband_pkg::ETYPE_OFS) begin
      ok = (d == ETYPE[15:8]);
    end else if (k == inband_pkg::ETYPE_OFS + 1) begin
      ok = (d == ETYPE[7:0]);
    end
    return ok;
  endfunction

  // Response byte source: the two addresses trade places
  function automatic logic [AW-1:0] tx_src(input logic [PW-1:0] i);
    logic [AW-1:0] s;
    s = i[AW-1:0];
    if (i < PW'(inband_pkg::SA_OFS)) begin
      s = i[AW-1:0] + AW'(inband_pkg::ADDR_BYTES);
    end else if (i < PW'(inband_pkg::TAG_TYPE_OFS)) begin
      s = i[AW-1:0] - AW'(inband_pkg::ADDR_BYTES);
    end
    return s;
  endfunction

  // ****************
  // Control register slave
  // ****************
  assign status = {drop_cnt, done_cnt, 15'h0000, state != inband_pkg::S_IDLE};

  inband_ctrl_regs u_regs (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .strap_en_i(strap_en_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i),
    .status_i(status),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .mgmt_en_o(mgmt_en),
    .mgmt_port_o(mgmt_port)
  );

  // ****************
  // Receive side classification
  // ****************
  // Other ports are ignored; the stream passes unaltered
  assign sel = rx_valid_i && mgmt_en && (rx_i.port == mgmt_port);
  assign byte_idx = rx_i.sof ? '0 : rx_cnt;
  assign hdr_run = (rx_i.sof ? 1'b1 : hdr_ok) && hdr_byte_ok(byte_idx, rx_i.data);
  assign cap_now = rx_i.sof ? (state == inband_pkg::S_IDLE) : cap;
  assign is_mgmt = sel && rx_i.eof && (byte_idx >= PW'(inband_pkg::HDR_BYTES)) && hdr_ok;
  // A frame that overflows the buffer is dropped rather than half executed
  assign start = is_mgmt && cap_now && (byte_idx < PW'(BUF_BYTES));
  assign rx_we = sel && cap_now && (byte_idx < PW'(BUF_BYTES));

  // Saturating count: a jumbo frame cannot wrap to a small length
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_cnt <= '0;
    end else if (sel) begin
      if (rx_i.sof) begin
        rx_cnt <= PW'(1);
      end else if (rx_cnt != '1) begin
        rx_cnt <= rx_cnt + PW'(1);
      end
    end
  end

  // Header signature tracking and the flags handed to the switch pipeline
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hdr_ok <= 1'b0;
      mgmt_frame_o <= 1'b0;
      fabric_discard_o <= 1'b0;
    end else begin
      fabric_discard_o <= is_mgmt;
      if (sel) begin
        if (byte_idx < PW'(inband_pkg::HDR_BYTES)) begin
          hdr_ok <= hdr_run;
        end
        if (rx_i.eof) begin
          mgmt_frame_o <= 1'b0;
        end else if (byte_idx == PW'(inband_pkg::HDR_BYTES - 1)) begin
          mgmt_frame_o <= hdr_run;
        end
      end
    end
  end

  // Capture arms only when idle, so a busy engine keeps its buffer
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cap <= 1'b0;
      len <= '0;
    end else if (sel) begin
      cap <= rx_i.eof ? 1'b0 : cap_now;
      if (start) begin
        len <= byte_idx + PW'(1);
      end
    end
  end

  // ****************
  // Frame buffer, one byte per entry
  // ****************
  assign ex_we = (state == inband_pkg::S_BUS) && sw_ack_i && sw_req_o.rd &&
                 (burst_on || op_r == inband_pkg::OP_READ);
  assign ex_widx = burst_on ? ptr[AW-1:0] : ptr[AW-1:0] + AW'(inband_pkg::WORD_BYTES);

  for (genvar gi = 0; gi < BUF_BYTES; gi++) begin : g_mem
    logic [AW-1:0] off;
    assign off = AW'(gi) - ex_widx;
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        mem[gi] <= 8'h00;
      end else if (rx_we && byte_idx[AW-1:0] == AW'(gi)) begin
        mem[gi] <= rx_i.data;
      end else if (ex_we && off < AW'(inband_pkg::WORD_BYTES)) begin
        // Read data lands where the request carried its data word
        mem[gi] <= sw_rdata_i[8 * (3 - int'(off[1:0])) +: 8];
      end
    end
  end

  // ****************
  // Command execution
  // ****************
  // A process, not an assign: a buffer write alone must refresh the words
  always_comb begin
    cw = word_at(ptr[AW-1:0]);
    dw = word_at(ptr[AW-1:0] + AW'(inband_pkg::WORD_BYTES));
  end
  assign mode = {mem[inband_pkg::CODE_OFS], mem[inband_pkg::CODE_OFS + 1]};
  assign tx_done = tx_valid_o && tx_ready_i && tx_o.last;

  // A wait never met holds the engine; status shows busy
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= inband_pkg::S_IDLE;
      ptr <= '0;
      sw_req_o <= '0;
      burst_on <= 1'b0;
      bdir <= 2'h0;
      baddr <= 24'h000000;
      bleft <= '0;
      op_r <= inband_pkg::OP_END;
      mask_r <= 32'h0000_0000;
      mod_wr <= 1'b0;
    end else begin
      case (state)
        inband_pkg::S_IDLE: begin
          if (start) begin
            state <= inband_pkg::S_FETCH;
            ptr <= PW'(inband_pkg::LIST_OFS);
            burst_on <= 1'b0;
            mod_wr <= 1'b0;
          end
        end
        inband_pkg::S_FETCH: begin
          if (mode == inband_pkg::MODE_SINGLE) begin
            if (ptr + PW'(inband_pkg::WORD_BYTES) > len ||
                cw[inband_pkg::OP_MSB -: 3] == inband_pkg::OP_END ||
                cw[inband_pkg::OP_MSB -: 3] == 3'h3 ||
                ptr + PW'(inband_pkg::CMD_BYTES) > len) begin
              state <= inband_pkg::S_TX;
            end else begin
              op_r <= cw[inband_pkg::OP_MSB -: 3];
              mask_r <= dw;
              sw_req_o.addr <= cw[23:0];
              sw_req_o.be <= cw[inband_pkg::BE_MSB -: 4];
              sw_req_o.wdata <= dw;
              sw_req_o.wr <= (cw[inband_pkg::OP_MSB -: 3] == inband_pkg::OP_WRITE);
              sw_req_o.rd <= (cw[inband_pkg::OP_MSB -: 3] != inband_pkg::OP_WRITE);
              state <= inband_pkg::S_BUS;
            end
          end else if (mode == inband_pkg::MODE_BURST) begin
            if (!burst_on) begin
              if (ptr + PW'(inband_pkg::CMD_BYTES) > len) begin
                state <= inband_pkg::S_TX;
              end else begin
                bdir <= cw[inband_pkg::DIR_MSB -: 2];
                baddr <= cw[23:0];
                bleft <= dw[inband_pkg::CNT_W-1:0];
                burst_on <= 1'b1;
                ptr <= ptr + PW'(inband_pkg::CMD_BYTES);
              end
            end else if (bleft == '0 || ptr + PW'(inband_pkg::WORD_BYTES) > len ||
                         !(bdir == inband_pkg::DIR_READ || bdir == inband_pkg::DIR_WRITE)) begin
              state <= inband_pkg::S_TX;
            end else begin
              sw_req_o.addr <= baddr;
              sw_req_o.be <= inband_pkg::BE_ALL;
              sw_req_o.wdata <= cw;
              sw_req_o.rd <= (bdir == inband_pkg::DIR_READ);
              sw_req_o.wr <= (bdir == inband_pkg::DIR_WRITE);
              state <= inband_pkg::S_BUS;
            end
          end else begin
            state <= inband_pkg::S_TX;
          end
        end
        inband_pkg::S_BUS: begin
          if (sw_ack_i) begin
            sw_req_o.rd <= 1'b0;
            sw_req_o.wr <= 1'b0;
            state <= inband_pkg::S_FETCH;
            if (burst_on) begin
              ptr <= ptr + PW'(inband_pkg::WORD_BYTES);
              baddr <= baddr + 24'h000004;
              bleft <= bleft - 1'b1;
            end else begin
              case (op_r)
                inband_pkg::OP_WAIT0: begin
                  // Not yet true: fetch again, which reissues the same read
                  if ((sw_rdata_i & mask_r) == 32'h0000_0000) begin
                    ptr <= ptr + PW'(inband_pkg::CMD_BYTES);
                  end
                end
                inband_pkg::OP_WAIT1: begin
                  if ((sw_rdata_i & mask_r) == mask_r) begin
                    ptr <= ptr + PW'(inband_pkg::CMD_BYTES);
                  end
                end
                inband_pkg::OP_CLR, inband_pkg::OP_SET: begin
                  if (!mod_wr) begin
                    // Read-modify-write: second access writes the patched word
                    mod_wr <= 1'b1;
                    sw_req_o.wr <= 1'b1;
                    sw_req_o.wdata <= (op_r == inband_pkg::OP_SET) ?
                                      (sw_rdata_i | mask_r) : (sw_rdata_i & ~mask_r);
                    state <= inband_pkg::S_BUS;
                  end else begin
                    mod_wr <= 1'b0;
                    ptr <= ptr + PW'(inband_pkg::CMD_BYTES);
                  end
                end
                default: ptr <= ptr + PW'(inband_pkg::CMD_BYTES);
              endcase
            end
          end
        end
        inband_pkg::S_TX: begin
          if (tx_done) begin
            state <= inband_pkg::S_IDLE;
          end
        end
        default: state <= inband_pkg::S_IDLE;
      endcase
    end
  end

  // ****************
  // Response transmit, one registered byte stage
  // ****************
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_valid_o <= 1'b0;
      tx_o <= '0;
      tx_idx <= '0;
    end else if (state != inband_pkg::S_TX) begin
      tx_valid_o <= 1'b0;
      tx_idx <= '0;
    end else if (!tx_valid_o || tx_ready_i) begin
      if (tx_idx < len) begin
        tx_valid_o <= 1'b1;
        tx_o.data <= mem[tx_src(tx_idx)];
        tx_o.last <= (tx_idx == len - PW'(1));
        tx_idx <= tx_idx + PW'(1);
      end else begin
        tx_valid_o <= 1'b0;
      end
    end
  end

  // Status counters: responses sent, frames refused
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      done_cnt <= 8'h00;
      drop_cnt <= 8'h00;
    end else begin
      if (tx_done) begin
        done_cnt <= done_cnt + 8'h01;
      end
      if (is_mgmt && !start) begin
        drop_cnt <= drop_cnt + 8'h01;
      end
    end
  end

endmodule

/* inband_register_access_checker.sv */
// Concurrent checks on the ports of the in-band management block.
// Assumes the single sys_clk_i domain and the asynchronous low reset.
`timescale 1ns/1ns
module inband_register_access_checker (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic rx_valid_i,
  input wire inband_pkg::rx_beat_t rx_i,
  input wire logic mgmt_frame_o,
  input wire logic fabric_discard_o,
  input wire inband_pkg::sw_req_t sw_req_o,
  input wire logic sw_ack_i,
  input wire logic tx_valid_o,
  input wire inband_pkg::tx_beat_t tx_o,
  input wire logic tx_ready_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o
);
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // Frame end and response end steps
  sequence mgmt_eof; mgmt_frame_o && rx_valid_i && rx_i.eof; endsequence
  sequence tx_end; tx_valid_o && tx_ready_i && tx_o.last; endsequence
  chk_discard_cause: assert property (fabric_discard_o |-> $past(rx_valid_i && rx_i.eof))
    else $error("discard without end of frame");
  chk_discard_on_end: assert property (mgmt_eof |=> fabric_discard_o)
    else $error("frame not discarded");
  chk_discard_once: assert property (fabric_discard_o |=> !fabric_discard_o)
    else $error("discard too long");
  chk_tag_seen: assert property ($rose(mgmt_frame_o) |-> $past(rx_valid_i))
    else $error("flag without header byte");
  chk_single_dir: assert property (!(sw_req_o.rd && sw_req_o.wr))
    else $error("read and write together");
  chk_req_held: assert property ((sw_req_o.rd || sw_req_o.wr) && !sw_ack_i |=> $stable(sw_req_o))
    else $error("request changed before ack");
  chk_tx_held: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_o))
    else $error("beat changed while stalled");
  chk_tx_done: assert property (tx_end |=> !tx_valid_o)
    else $error("beat after last byte");
  chk_no_bus_in_tx: assert property (tx_valid_o |-> !(sw_req_o.rd || sw_req_o.wr))
    else $error("bus access during response");
  chk_avs_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o)
    else $error("access not answered");
  chk_avs_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
endmodule
bind inband_register_access inband_register_access_checker u_chk (.sys_clk_i, .rst_b_i,
  .rx_valid_i, .rx_i, .mgmt_frame_o, .fabric_discard_o, .sw_req_o, .sw_ack_i, .tx_valid_o,
  .tx_o, .tx_ready_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o);

/* sw_reg_model.sv */
// Register space model on the switch register bus side of the block.
// Assumes one request at a time, held until the one-cycle acknowledge.
`timescale 1ns/1ns
module sw_reg_model (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire inband_pkg::sw_req_t req_i,
  output logic [31:0] rdata_o,
  output logic ack_o
);
  // ****************
  // Word store: even words answer at once, odd words three cycles late
  // ****************
  logic [31:0] mem [64];
  logic [1:0] dly;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dly <= 2'h0;
      ack_o <= 1'b0;
      rdata_o <= 32'h0;
      for (int i = 0; i < 64; i++) mem[i] <= 32'h0;
    end else if ((req_i.rd || req_i.wr) && !ack_o && dly == {2{req_i.addr[2]}}) begin
      dly <= 2'h0;
      ack_o <= 1'b1;
      rdata_o <= req_i.rd ? mem[req_i.addr[7:2]] : ~rdata_o; // Whole words
      for (int b = 0; b < 4; b++) begin
        if (req_i.wr && req_i.be[b]) mem[req_i.addr[7:2]][8*b +: 8] <= req_i.wdata[8*b +: 8];
      end
    end else begin
      dly <= ((req_i.rd || req_i.wr) && !ack_o) ? dly + 2'h1 : 2'h0;
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o; // Stale data never passes as an answer
    end
  end
endmodule

/* inband_register_access_tb.sv */
// Self-checking bench: Avalon register tasks, management frames, response capture.
// Assumes the package, design, checker and register model compile first.
`timescale 1ns/1ns
module inband_register_access_tb;
  // ****************
  // Signals, design and register model
  // ****************
  localparam logic [47:0] MAC = 48'h0200_1234_5601; // Arbitrary switch address
  localparam logic [31:0] SL [16] = '{32'h4f000010, 32'h12345600, 32'h43000014, 32'haabbccdd,
    32'hef000010, 32'h000000ff, 32'hcf000010, 32'h000000f0, 32'haf000010, 32'h0000000f,
    32'h8f000010, 32'h000000f0, 32'h2f000010, 32'h0, 32'h0, 32'h0};
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic strap_en = 1'b1;
  logic rx_valid_i = 1'b0;
  logic tx_ready_i = 1'b0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [3:0] avs_address_i = 4'h0;
  logic [31:0] avs_writedata_i = 32'h0;
  inband_pkg::rx_beat_t rx_i = '0;
  inband_pkg::sw_req_t sw_req_o;
  inband_pkg::tx_beat_t tx_o;
  logic [31:0] sw_rdata_i, avs_readdata_o, q;
  logic sw_ack_i, tx_valid_o, mgmt_frame_o, fabric_discard_o, avs_waitrequest_o;
  logic [7:0] fr[$], ex[$], rq[$];
  int fail_count = 0;
  int n_compared = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  // Half-rate ready stalls the response on every other cycle
  always @(posedge sys_clk_i) tx_ready_i <= ~tx_ready_i;
  always @(posedge sys_clk_i) if (tx_valid_o && tx_ready_i) rq.push_back(tx_o.data);
  inband_register_access u_inband_register_access (.sys_clk_i, .rst_b_i, .strap_en_i(strap_en),
    .switch_mac_i(MAC), .rx_valid_i, .rx_i, .mgmt_frame_o, .fabric_discard_o, .sw_req_o,
    .sw_rdata_i, .sw_ack_i, .tx_valid_o, .tx_o, .tx_ready_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i(4'hf), .avs_readdata_o, .avs_waitrequest_o);
  // No serial PHY management runs beside in-band access
  sw_reg_model u_sw_reg_model (.clk_i(sys_clk_i), .rst_b_i, .req_i(sw_req_o),
    .rdata_o(sw_rdata_i), .ack_o(sw_ack_i));
  // ****************
  // Tasks
  // ****************
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 2000) begin
      fail_count++;
      final_report();
    end
  endtask
  // One Avalon access, held until waitrequest is sampled low
  task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    avs_writedata_i <= d;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 2000);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    tmo(n);
  endtask
  task automatic w32(input logic [31:0] v);
    for (int k = 3; k >= 0; k--) fr.push_back(v[8*k +: 8]);
  endtask
  task automatic hdr(input logic [15:0] code);
    fr.delete();
    for (int k = 5; k >= 0; k--) fr.push_back(MAC[8*k +: 8]);
    w32(32'h02112233);
    w32(32'h44555a00);
    w32(32'ha35c0000); // Priority, zero canonical bit, mode, sequence
    w32({16'h0, code});
  endtask
  task automatic mkex();
    ex = fr;
    for (int i = 0; i < 12; i++) ex[i] = fr[(i + 6) % 12];
  endtask
  task automatic put(input int o, input logic [31:0] v);
    for (int k = 0; k < 4; k++) ex[o+k] = v[31-8*k -: 8];
  endtask
  task automatic send(input logic [2:0] p);
    for (int i = 0; i < fr.size(); i++) begin
      @(posedge sys_clk_i);
      rx_valid_i <= 1'b1;
      rx_i <= '{i == 0, i == fr.size() - 1, p, fr[i]};
    end
    @(posedge sys_clk_i);
    rx_valid_i <= 1'b0;
  endtask
  task automatic rsp();
    int n;
    n = 0;
    while (rq.size() < ex.size() && n < 2000) begin
      @(posedge sys_clk_i);
      n++;
    end
    tmo(n);
    repeat (4) @(posedge sys_clk_i);
    chk("rsp_len", ex.size(), rq.size());
    foreach (ex[i]) chk("rsp_byte", ex[i], rq[i]);
    rq.delete();
  endtask
  // ****************
  // Sequence of tests
  // ****************
  initial begin
    repeat (6) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    @(posedge sys_clk_i);
    avs(1'b0, 4'h0, 32'h0);
    chk("ctrl", 32'h71, q & 32'h71);
    avs(1'b0, 4'hc, 32'h0);
    chk("unmapped", 32'h0, q);
    hdr(16'h0001);
    foreach (SL[i]) w32(SL[i]);
    mkex();
    put(74, 32'h1234560f);
    send(3'h7);
    hdr(16'h0002);
    w32(32'h40000010);
    w32(32'h2);
    w32(32'h0);
    w32(32'h0);
    send(3'h7);
    rsp();
    avs(1'b0, 4'h4, 32'h0);
    chk("stat", 32'h0101, {16'h0, q[31:24], q[23:16]});
    avs(1'b1, 4'h0, 32'h31);
    avs(1'b0, 4'h0, 32'h0);
    chk("ctrl_port", 32'h31, q & 32'h71);
    send(3'h7);
    repeat (300) @(posedge sys_clk_i);
    chk("old_port", 32'h0, rq.size());
    mkex();
    put(30, 32'h1234560f);
    put(34, 32'h0000ccdd);
    send(3'h3);
    rsp();
    // Mid-run reset with the strap low: management off, port back to default
    strap_en <= 1'b0;
    rst_b_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    @(posedge sys_clk_i);
    avs(1'b0, 4'h0, 32'h0);
    chk("ctrl_strap", 32'h70, q & 32'h71);
    final_report();
  end
endmodule
